// file: rtl/iosh_pkg.sv
/*
 package for the station i/o strobe and handshake control block:
 packet fields, register map, strobe timing and shared carriers.
 assumes a single 200 mhz clock domain.
*/
package iosh_pkg;

	localparam int IOSH_W = 16;
	localparam int IOSH_AW = 8;

	// command values that ask for an input sample
	localparam logic [3:0] IOSH_CMD_BASIC_A = 4'h0;
	localparam logic [3:0] IOSH_CMD_BASIC_B = 4'h8;

	// strobe length in cycles and the cycle whose closing edge is the midpoint
	localparam logic [7:0] IOSH_STB_CYC = 8'h02;
	localparam logic [7:0] IOSH_STB_MID = 8'h00;
	localparam logic [7:0] IOSH_CNT_ONE = 8'h01;
	localparam logic [15:0] IOSH_ALL_ONES = 16'hffff;
	localparam logic [15:0] IOSH_CNT_INC = 16'h0001;

	// register byte offsets
	localparam logic [7:0] IOSH_REG_CTRL = 8'h00;
	localparam logic [7:0] IOSH_REG_STATUS = 8'h04;
	localparam logic [7:0] IOSH_REG_OUT = 8'h08;
	localparam logic [7:0] IOSH_REG_SAMPLE = 8'h0c;
	localparam logic [7:0] IOSH_REG_UPD_CNT = 8'h10;
	localparam logic [7:0] IOSH_REG_SMP_CNT = 8'h14;
	localparam logic [7:0] IOSH_REG_SKIP_CNT = 8'h18;

	// control and status field positions
	localparam int IOSH_CTRL_SOFT_CLR = 0;
	localparam int IOSH_ST_BUSY = 0;
	localparam int IOSH_ST_FORCED = 1;

	localparam logic [1:0] IOSH_RESP_OKAY = 2'h0;
	localparam logic [1:0] IOSH_RESP_SLVERR = 2'h2;

	// one decoded command packet from the packet receiver
	typedef struct packed {
		logic valid;
		logic [5:0] addr;
		logic [3:0] code;
		logic [15:0] data;
		logic prev_ok;
	} iosh_cmd_s;

	// one register write from the bus slave
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} iosh_wreq_s;

	typedef enum logic [1:0] {
		IOSH_SEQ_IDLE,
		IOSH_SEQ_FIRST,
		IOSH_SEQ_SECOND
	} iosh_seq_e;

endpackage

// file: rtl/iosh_strobe_gen.sv
/*
 fixed length strobe pulse generator with start, midpoint and last markers.
 assumes start is only raised while the generator is idle.
*/
`timescale 1ns/1ps
module iosh_strobe_gen import iosh_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	output logic strobe,
	output logic mid,
	output logic done
);

	typedef struct packed {
		logic active;
		logic [7:0] cnt;
	} iosh_stb_s;

	iosh_stb_s st_q, st_d;

	// count the high cycles of the pulse
	always_comb begin
		st_d = st_q;
		if (st_q.active) begin
			st_d.cnt = st_q.cnt + IOSH_CNT_ONE;
			if (st_q.cnt == IOSH_STB_CYC - IOSH_CNT_ONE) begin
				st_d.active = 1'b0;
			end
		end else if (start) begin
			st_d.active = 1'b1;
			st_d.cnt = '0;
		end
		if (!aresetn) begin
			st_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	// markers are decoded, the strobe itself is a flop
	assign strobe = st_q.active;
	assign mid = st_q.active && (st_q.cnt == IOSH_STB_MID);
	assign done = st_q.active && (st_q.cnt == IOSH_STB_CYC - IOSH_CNT_ONE);

endmodule

// file: rtl/iosh_axil_slave.sv
/*
 axi4-lite slave front end: takes address and data in either order,
 hands one write or one read to the register file, answers in order.
 assumes the register file decodes reads combinationally.
*/
`timescale 1ns/1ps
module iosh_axil_slave import iosh_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output iosh_wreq_s wreq,
	input wire logic wr_err,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iosh_axi_s;

	iosh_axi_s st_q, st_d;

	// handshake readies are combinational from the state
	assign s_axil_awready = !st_q.aw_got && !st_q.bvalid;
	assign s_axil_wready = !st_q.w_got && !st_q.bvalid;
	assign s_axil_arready = !st_q.rvalid;
	assign rd_addr = s_axil_araddr;
	// one driver for the whole carrier, so no tool sees a split variable
	assign wreq = '{en: st_q.aw_got && st_q.w_got && !st_q.bvalid, addr: st_q.awaddr,
		data: st_q.wdata, strb: st_q.wstrb};

	// collect the write halves, then answer; reads answer one cycle later
	always_comb begin
		st_d = st_q;
		if (s_axil_awvalid && s_axil_awready) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			st_d.w_got = 1'b1;
			st_d.wdata = s_axil_wdata;
			st_d.wstrb = s_axil_wstrb;
		end
		if (wreq.en) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wr_err ? IOSH_RESP_SLVERR : IOSH_RESP_OKAY;
		end
		if (st_q.bvalid && s_axil_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (s_axil_arvalid && s_axil_arready) begin
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_data;
			st_d.rresp = rd_err ? IOSH_RESP_SLVERR : IOSH_RESP_OKAY;
		end else if (st_q.rvalid && s_axil_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (!aresetn) begin
			st_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	assign s_axil_bvalid = st_q.bvalid;
	assign s_axil_bresp = st_q.bresp;
	assign s_axil_rvalid = st_q.rvalid;
	assign s_axil_rdata = st_q.rdata;
	assign s_axil_rresp = st_q.rresp;

endmodule

// file: rtl/iosh_io_strobe_ctrl.sv
/*
 station side control of the sixteen parallel outputs and inputs:
 output update and input sample strobes, their order, the response
 handshake, the forced clear, and a small axi4-lite register file.
 assumes the packet receiver delivers one decoded command per pulse
 and takes the response word on its valid pulse.
*/
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module iosh_io_strobe_ctrl import iosh_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input iosh_cmd_s cmd,
	input wire logic [5:0] station_number_pins,
	input wire logic force_outputs_low_input,
	input wire logic strobe_order_select,
	input wire logic handshake_select,
	input wire logic [15:0] input_pins,
	output logic [15:0] output_pins,
	output logic output_update_strobe,
	output logic input_sample_strobe,
	output logic [15:0] response_word,
	output logic response_fresh,
	output logic response_valid,
	output logic cmd_busy,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready
);

	typedef struct packed {
		iosh_seq_e seq;
		logic first_is_in;
		logic do_in;
		logic [15:0] pend_data;
		logic [15:0] out_word;
		logic [15:0] sample;
		logic fresh;
		logic [15:0] resp_word;
		logic resp_fresh;
		logic resp_valid;
		logic rst_seen;
		logic soft_clear;
		logic [15:0] upd_cnt;
		logic [15:0] smp_cnt;
		logic [15:0] skip_cnt;
	} iosh_ctl_s;

	iosh_ctl_s st_q, st_d;

	iosh_wreq_s wreq;
	logic wr_err;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;

	logic out_start;
	logic in_start;
	logic out_mid;
	logic out_done;
	logic in_mid;
	logic in_done;
	logic force_low;
	logic hit;
	logic basic;
	logic take_in;
	logic phase_in;
	logic phase_done;

	// register bus front end
	iosh_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.wreq(wreq),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// output update strobe, two cycles high
	iosh_strobe_gen u_out_stb (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(out_start),
		.strobe(output_update_strobe),
		.mid(out_mid),
		.done(out_done)
	);

	// input sample strobe, two cycles high
	iosh_strobe_gen u_in_stb (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(in_start),
		.strobe(input_sample_strobe),
		.mid(in_mid),
		.done(in_done)
	);

	// clear is a raw level, so even a one-cycle glitch forces the pins
	assign force_low = force_outputs_low_input || st_q.soft_clear;

	// packet qualification; a sequence in flight refuses new packets
	assign hit = cmd.valid && (cmd.addr == station_number_pins) && !st_q.rst_seen;
	assign basic = (cmd.code == IOSH_CMD_BASIC_A) || (cmd.code == IOSH_CMD_BASIC_B);
	// confirmation only matters with the handshake pin low
	assign take_in = basic && (handshake_select || cmd.prev_ok);

	// which strobe is running in the current phase
	always_comb begin
		phase_in = 1'b0;
		case (st_q.seq)
			IOSH_SEQ_FIRST: begin
				phase_in = st_q.first_is_in;
			end
			IOSH_SEQ_SECOND: begin
				phase_in = !st_q.first_is_in;
			end
			default: begin
				phase_in = 1'b0;
			end
		endcase
	end

	assign phase_done = phase_in ? in_done : out_done;

	// strobe starts come straight from the sequencer
	always_comb begin
		out_start = 1'b0;
		in_start = 1'b0;
		case (st_q.seq)
			IOSH_SEQ_IDLE: begin
				if (hit && aresetn) begin
					// order pin low puts sampling first
					if (!strobe_order_select && take_in) begin
						in_start = 1'b1;
					end else begin
						out_start = 1'b1;
					end
				end
			end
			IOSH_SEQ_FIRST: begin
				if (phase_done && st_q.do_in && aresetn) begin
					if (st_q.first_is_in) begin
						out_start = 1'b1;
					end else begin
						in_start = 1'b1;
					end
				end
			end
			default: begin
				out_start = 1'b0;
				in_start = 1'b0;
			end
		endcase
	end

	// sequencer, output word, sample word and counters
	always_comb begin
		st_d = st_q;
		st_d.resp_valid = 1'b0;
		case (st_q.seq)
			IOSH_SEQ_IDLE: begin
				if (hit) begin
					st_d.seq = IOSH_SEQ_FIRST;
					st_d.pend_data = cmd.data;
					st_d.do_in = take_in;
					st_d.first_is_in = !strobe_order_select && take_in;
					st_d.fresh = 1'b0;
					if (basic && !take_in) begin
						// unconfirmed response: keep the old sample for resending
						st_d.skip_cnt = st_q.skip_cnt + IOSH_CNT_INC;
					end
				end
			end
			IOSH_SEQ_FIRST: begin
				if (phase_done) begin
					st_d.seq = st_q.do_in ? IOSH_SEQ_SECOND : IOSH_SEQ_IDLE;
				end
			end
			IOSH_SEQ_SECOND: begin
				if (phase_done) begin
					st_d.seq = IOSH_SEQ_IDLE;
				end
			end
			default: begin
				st_d.seq = IOSH_SEQ_IDLE;
			end
		endcase

		// sequence end hands the sample word to the response
		if ((st_q.seq != IOSH_SEQ_IDLE) && (st_d.seq == IOSH_SEQ_IDLE)) begin
			st_d.resp_valid = 1'b1;
			st_d.resp_word = st_d.sample;
			st_d.resp_fresh = st_d.fresh;
		end

		// input captured on the edge where the sample strobe rises
		if (in_start) begin
			st_d.sample = force_low ? IOSH_ALL_ONES : input_pins;
			st_d.fresh = 1'b1;
			st_d.smp_cnt = st_q.smp_cnt + IOSH_CNT_INC;
		end

		// new word lands on the midpoint edge, even if unchanged
		if (out_mid) begin
			st_d.out_word = st_q.pend_data;
			st_d.upd_cnt = st_q.upd_cnt + IOSH_CNT_INC;
		end

		// clear throws the held word away and beats any update
		if (force_low) begin
			st_d.out_word = '0;
		end

		// software control register
		if (wreq.en && (wreq.addr == IOSH_REG_CTRL) && wreq.strb[0]) begin
			st_d.soft_clear = wreq.data[IOSH_CTRL_SOFT_CLR];
		end

		// reset holds the pins, the first cycle after release drops them
		if (st_q.rst_seen) begin
			st_d.out_word = '0;
			st_d.rst_seen = 1'b0;
		end
		if (!aresetn) begin
			st_d = '0;
			st_d.out_word = st_q.out_word;
			st_d.rst_seen = 1'b1;
		end
	end

	// only synchronous reset, so holding a field through reset is legal
	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	// output pins mask the held word with the raw clear level
	assign output_pins = force_low ? '0 : st_q.out_word;
	assign response_word = st_q.resp_word;
	assign response_fresh = st_q.resp_fresh;
	assign response_valid = st_q.resp_valid;
	assign cmd_busy = (st_q.seq != IOSH_SEQ_IDLE) || st_q.rst_seen;

	// only the control register takes writes
	assign wr_err = wreq.addr != IOSH_REG_CTRL;

	// read decode; unmapped offsets answer slverr with zero data
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		case (rd_addr)
			IOSH_REG_CTRL: begin
				rd_data[IOSH_CTRL_SOFT_CLR] = st_q.soft_clear;
			end
			IOSH_REG_STATUS: begin
				rd_data[IOSH_ST_BUSY] = cmd_busy;
				rd_data[IOSH_ST_FORCED] = force_low;
			end
			IOSH_REG_OUT: begin
				rd_data[IOSH_W-1:0] = output_pins;
			end
			IOSH_REG_SAMPLE: begin
				rd_data[IOSH_W-1:0] = st_q.sample;
			end
			IOSH_REG_UPD_CNT: begin
				rd_data[IOSH_W-1:0] = st_q.upd_cnt;
			end
			IOSH_REG_SMP_CNT: begin
				rd_data[IOSH_W-1:0] = st_q.smp_cnt;
			end
			IOSH_REG_SKIP_CNT: begin
				rd_data[IOSH_W-1:0] = st_q.skip_cnt;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

endmodule

// file: bench/iosh_io_strobe_ctrl_chk.sv
/*
 checker for the station i/o strobe block: strobe shapes, clear, order,
 response words. sees only the top module ports, one clock domain.
*/
`timescale 1ns/1ps
module iosh_io_strobe_ctrl_chk import iosh_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic force_outputs_low_input,
	input wire logic strobe_order_select,
	input wire logic [15:0] input_pins,
	input wire logic [15:0] output_pins,
	input wire logic output_update_strobe,
	input wire logic input_sample_strobe,
	input wire logic [15:0] response_word,
	input wire logic response_fresh,
	input wire logic response_valid,
	input wire logic cmd_busy
);
	logic [15:0] pin_q;
	logic [15:0] smp_q;
	logic stb_q;

	// pins as the sampling edge saw them; clear reads as all ones
	always_ff @(posedge aclk) begin
		pin_q <= force_outputs_low_input ? IOSH_ALL_ONES : input_pins;
		stb_q <= input_sample_strobe;
		if (input_sample_strobe && !stb_q) begin
			smp_q <= pin_q;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	clear_low_a: assert property (force_outputs_low_input |-> output_pins == 16'h0000)
		else $error("outputs not low under clear");
	upd_pulse_a: assert property ($rose(output_update_strobe) |=>
		output_update_strobe ##1 !output_update_strobe) else $error("update strobe width");
	smp_pulse_a: assert property ($rose(input_sample_strobe) |=>
		input_sample_strobe ##1 !input_sample_strobe) else $error("sample strobe width");
	upd_resp_a: assert property (response_valid |->
		$past(output_update_strobe, 2) || $past(output_update_strobe, 4))
		else $error("response without update strobe");
	// settled outputs may only move at the strobe midpoint
	out_change_a: assert property ((!force_outputs_low_input &&
		!$past(force_outputs_low_input) && $past(aresetn, 2) && output_pins != $past(output_pins))
		|-> output_update_strobe && $past(output_update_strobe)) else $error("output moved");
	reset_low_a: assert property ($rose(aresetn) |=> output_pins == 16'h0000)
		else $error("outputs not low after reset");
	sample_word_a: assert property (response_valid && response_fresh |->
		response_word == smp_q) else $error("fresh word differs from sample");
	resend_word_a: assert property (response_valid && !response_fresh |->
		response_word == $past(response_word) && !$past(input_sample_strobe) &&
		!$past(input_sample_strobe, 2)) else $error("resent word wrong");
	strobe_order_a: assert property ($rose(input_sample_strobe) |->
		##2 output_update_strobe == !strobe_order_select) else $error("strobe order");
	busy_strobe_a: assert property ((output_update_strobe || input_sample_strobe) |-> cmd_busy)
		else $error("strobe while not busy");

	cover property (response_valid && response_fresh);
	cover property (response_valid && !response_fresh);
	cover property (force_outputs_low_input && output_update_strobe);
endmodule

bind iosh_io_strobe_ctrl iosh_io_strobe_ctrl_chk i_iosh_io_strobe_ctrl_chk (.aclk, .aresetn,
	.force_outputs_low_input, .strobe_order_select, .input_pins, .output_pins,
	.output_update_strobe, .input_sample_strobe, .response_word, .response_fresh,
	.response_valid, .cmd_busy);

// file: bench/iosh_centre_model.sv
/*
 centre controller model: sends decoded command packets to the station
 and collects its answer. assumes an answer within eight cycles or none.
*/
`timescale 1ns/1ps
module iosh_centre_model import iosh_pkg::*; (
	input wire logic aclk,
	output iosh_cmd_s cmd,
	input wire logic [15:0] response_word,
	input wire logic response_fresh,
	input wire logic response_valid
);
	initial cmd = '0;

	// one packet; idle lines carry the inverse so stale fields never pass
	task automatic scan(input logic [5:0] a, input logic [3:0] c, input logic [15:0] d,
		input logic ok, output logic got, output logic [15:0] w, output logic f);
		int n;
		cmd <= '{1'b1, a, c, d, ok};
		@(posedge aclk);
		cmd <= '{1'b0, ~a, ~c, ~d, ~ok};
		got = 1'b0;
		for (n = 0; n < 8 && !got; n++) begin
			@(posedge aclk);
			got = response_valid;
			w = response_word;
			f = response_fresh;
		end
	endtask
endmodule

// file: bench/iosh_io_strobe_ctrl_tb.sv
/*
 testbench for the station i/o strobe block: packets from the centre
 model, registers over axi4-lite. assumes station number 5, one clock.
*/
`timescale 1ns/1ps
module iosh_io_strobe_ctrl_tb import iosh_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clr = 1'b0;
	logic order_sel = 1'b1;
	logic hs_sel = 1'b1;
	logic [15:0] din = 16'h0000;
	logic [15:0] dout, rword, g_w, exp_w;
	logic ustb, sstb, rfresh, rvalid, g_got, g_f;
	iosh_cmd_s cmd;
	logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
	logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
	logic [3:0] s_axil_wstrb = 4'hf;
	logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
	logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0] s_axil_bresp, s_axil_rresp;
	int error_cnt = 0, tests_run = 0, i;

	always #2.5 aclk = ~aclk;

	iosh_io_strobe_ctrl i_iosh_io_strobe_ctrl (.aclk, .aresetn, .cmd,
		.station_number_pins(6'h05), .force_outputs_low_input(clr),
		.strobe_order_select(order_sel), .handshake_select(hs_sel), .input_pins(din),
		.output_pins(dout), .output_update_strobe(ustb), .input_sample_strobe(sstb),
		.response_word(rword), .response_fresh(rfresh), .response_valid(rvalid),
		.cmd_busy(), .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
		.s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
		.s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
		.s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);

	iosh_centre_model i_iosh_centre_model (.aclk, .cmd, .response_word(rword),
		.response_fresh(rfresh), .response_valid(rvalid));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: resp %h expected %h", $time, g, e);
		end
	endtask

	// each channel held until its own ready; 2'h3 marks no answer
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		r = 2'h3;
		// no cycle count assumed; only the watchdog ends a hung wait
		while (r === 2'h3) begin
			@(posedge aclk);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
			if (s_axil_bvalid) begin
				r = s_axil_bresp;
				s_axil_bready <= 1'b0;
			end
		end
		@(posedge aclk);
		chk_resp(r, er);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [1:0] r;
		logic [31:0] d;
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		r = 2'h3;
		while (r === 2'h3) begin
			@(posedge aclk);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
			if (s_axil_rvalid) begin
				r = s_axil_rresp;
				d = s_axil_rdata;
				s_axil_rready <= 1'b0;
			end
		end
		@(posedge aclk);
		chk_resp(r, er);
		chk(d, e);
	endtask

	task automatic sc(input logic [3:0] c, input logic [15:0] d, input logic ok);
		i_iosh_centre_model.scan(6'h05, c, d, ok, g_got, g_w, g_f);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(32'(dout), 32'h0);
		// soft clear only while the held word is zero
		axi_rd(IOSH_REG_CTRL, 32'h0, IOSH_RESP_OKAY);
		axi_wr(IOSH_REG_CTRL, 32'h1, IOSH_RESP_OKAY);
		axi_rd(IOSH_REG_STATUS, 32'h2, IOSH_RESP_OKAY);
		axi_wr(IOSH_REG_CTRL, 32'h0, IOSH_RESP_OKAY);
		axi_wr(IOSH_REG_STATUS, 32'h3, IOSH_RESP_SLVERR);
		axi_wr(8'h40, 32'h1, IOSH_RESP_SLVERR);
		axi_rd(8'h40, 32'h0, IOSH_RESP_SLVERR);
		// repeated word still strobes; a foreign address changes nothing
		sc(4'h3, 16'ha5c3, 1'b1);
		chk(32'(dout), 32'ha5c3);
		sc(4'h3, 16'ha5c3, 1'b1);
		axi_rd(IOSH_REG_UPD_CNT, 32'h2, IOSH_RESP_OKAY);
		i_iosh_centre_model.scan(6'h06, 4'h0, 16'h1111, 1'b1, g_got, g_w, g_f);
		chk(32'(g_got), 32'h0);
		chk(32'(dout), 32'ha5c3);
		axi_rd(IOSH_REG_UPD_CNT, 32'h2, IOSH_RESP_OKAY);
		// every command value, order pin toggled, sampling commands only with sampling first, handshake off
		exp_w = 16'h0000;
		for (i = 0; i < 16; i++) begin
			order_sel <= i[0];
			din <= {12'h3c0, i[3:0]};
			sc(i[3:0], {12'h5a0, i[3:0]}, 1'b1);
			if (i == 0 || i == 8) exp_w = {12'h3c0, i[3:0]};
			chk(32'(dout), {20'h005a0, i[3:0]});
			chk(32'(g_f), 32'(i == 0 || i == 8));
			chk(32'(g_w), 32'(exp_w));
		end
		// handshake on: fresh sample only after a confirmed answer
		hs_sel <= 1'b0;
		din <= 16'h1234;
		sc(4'h0, 16'h0001, 1'b1);
		chk(32'(g_w), 32'h1234);
		din <= 16'h5678;
		sc(4'h8, 16'h0002, 1'b0);
		chk(32'(g_f), 32'h0);
		chk(32'(g_w), 32'h1234);
		sc(4'h8, 16'h0003, 1'b1);
		chk(32'(g_w), 32'h5678);
		hs_sel <= 1'b1;
		din <= 16'h9abc;
		sc(4'h0, 16'h0004, 1'b0);
		chk(32'(g_w), 32'h9abc);
		// clear as a level, then as a one-cycle glitch
		clr <= 1'b1;
		sc(4'h0, 16'h7777, 1'b1);
		chk(32'(dout), 32'h0);
		chk(32'(g_w), 32'hffff);
		clr <= 1'b0;
		sc(4'h3, 16'h00ff, 1'b1);
		chk(32'(dout), 32'h00ff);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		chk(32'(dout), 32'h0);
		@(posedge aclk);
		chk(32'(dout), 32'h0);
		axi_rd(IOSH_REG_SAMPLE, 32'hffff, IOSH_RESP_OKAY);
		// six fresh samples so far, one skipped while unconfirmed
		axi_rd(IOSH_REG_SMP_CNT, 32'h6, IOSH_RESP_OKAY);
		axi_rd(IOSH_REG_SKIP_CNT, 32'h1, IOSH_RESP_OKAY);
		// mid-run reset holds the pins, release drops them
		sc(4'h3, 16'hbeef, 1'b1);
		chk(32'(dout), 32'hbeef);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(32'(dout), 32'hbeef);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(32'(dout), 32'h0);
		complete_run();
	end
endmodule
